// *** cmp_model.sv ***
// comparator model beside the sequencer
// level_in stands for the analog input as a code
`timescale 1ns/1ps
module cmp_model (
  input wire logic [11:0] level_in,
  input wire logic [11:0] dac_in,
  output logic comp_high_out
);
  assign comp_high_out = level_in >= dac_in;
endmodule : cmp_model

// *** sar_adc_chk.sv ***
// port checker for the sequencer
// bound to sar_adc_control
`timescale 1ns/1ps
module sar_adc_chk #(parameter int unsigned STEP_CYCLES = 100) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic trigger_in,
  input wire logic inhibit_n_in,
  input wire logic twos_comp_in,
  input wire logic [11:0] dac_code_out,
  input wire logic busy_out,
  input wire logic serial_data_out,
  input wire logic [11:0] result_out,
  input wire logic msb_n_out,
  input wire logic [11:0] result_tc_out
);
  logic [15:0] cnt_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 16'h0;
    end else begin
      cnt_r <= busy_out ? cnt_r + 16'h1 : 16'h0;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_start; $rose(busy_out); endsequence
  property p_msb; msb_n_out == !result_out[11]; endproperty
  a_msb: assert property (p_msb) else $error("msb_n wrong");
  property p_tc; result_tc_out == (twos_comp_in ? result_out ^ 12'h800 : result_out); endproperty
  a_tc: assert property (p_tc) else $error("coded result wrong");
  property p_start; s_start |-> dac_code_out == 12'h800; endproperty
  a_start: assert property (p_start) else $error("first trial wrong");
  property p_len; $fell(busy_out) |-> cnt_r == 16'(12 * STEP_CYCLES); endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_ser; $changed(serial_data_out) |-> $past(busy_out); endproperty
  a_ser: assert property (p_ser) else $error("serial moved when idle");
  property p_res; $changed(result_out) |-> $fell(busy_out); endproperty
  a_res: assert property (p_res) else $error("result moved");
  property p_inh; (!inhibit_n_in) [*4] |=> !$rose(busy_out); endproperty
  a_inh: assert property (p_inh) else $error("start while inhibited");
  property p_lvl; trigger_in [*6] |-> not s_start; endproperty
  a_lvl: assert property (p_lvl) else $error("start without edge");
endmodule : sar_adc_chk
bind sar_adc_control sar_adc_chk #(.STEP_CYCLES(STEP_CYCLES)) sar_adc_chk_i (.*);

// *** sar_adc_control.sv ***
// sequencer of a 12-bit successive-approximation converter
// assumes an external dac and comparator; trigger, inhibit and comparator pins synchronised here, two's complement select used directly
`timescale 1ns/1ps

// Summary of operation
// - A conversion starts only on a falling edge of the trigger input, or when reset ends with the trigger already low.
// - Trigger edges are ignored while inhibit is low; the user holds it high to convert.
// - End of conversion is high for the whole conversion and falls when the result is valid.
// - The result is resolved over twelve steps by successive approximation, one bit per step.
// - An internal step timer paces the conversion, settable for 12 to 48 us in total.
// - Each decided bit is presented on the serial NRZ output as it is decided.
// - The unipolar coding is straight binary from zero.
// - The bipolar coding is offset binary or, by selection, two's complement.
// - The parallel output shows the true value of all bits at once.
// - The complemented most significant bit is also presented for two's complement use.
module sar_adc_control #(
  parameter int unsigned STEP_CYCLES = 100
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic trigger_in,
  input wire logic inhibit_n_in,
  input wire logic twos_comp_in,
  input wire logic comp_high_in,
  output logic [11:0] dac_code_out,
  output logic busy_out,
  output logic serial_data_out,
  output logic [11:0] result_out,
  output logic msb_n_out,
  output logic [11:0] result_tc_out
);

  initial begin
    if (STEP_CYCLES < sar_adc_pkg::STEP_MIN_CYC || STEP_CYCLES > sar_adc_pkg::STEP_MAX_CYC) begin
      $error("STEP_CYCLES outside conversion time range");
    end
  end

  localparam logic [7:0] STEP_LAST = 8'(STEP_CYCLES - 1);

  typedef struct packed {
    logic [1:0] trig_sync;
    logic [1:0] inh_sync;
    logic [1:0] cmp_sync;
    logic trig_prev;
    sar_adc_pkg::seq_state_t state;
    logic [7:0] step_cnt;
    logic [11:0] probe;
    logic [11:0] sar;
    logic [11:0] result;
    logic busy;
    logic serial;
  } state_t;

  state_t cur_r;
  state_t cur_nxt;

  logic trig_fall;
  logic [11:0] decided;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.trig_sync = {cur_r.trig_sync[0], trigger_in};
    cur_nxt.inh_sync = {cur_r.inh_sync[0], inhibit_n_in};
    cur_nxt.cmp_sync = {cur_r.cmp_sync[0], comp_high_in};
    cur_nxt.trig_prev = cur_r.trig_sync[1];
    trig_fall = cur_r.trig_prev & ~cur_r.trig_sync[1];
    // keep or drop the trial bit
    decided = cur_r.cmp_sync[1] ? cur_r.sar : (cur_r.sar & ~cur_r.probe);
    case (cur_r.state)
      sar_adc_pkg::ST_IDLE: begin
        if (trig_fall && cur_r.inh_sync[1]) begin
          cur_nxt.state = sar_adc_pkg::ST_DECIDE;
          cur_nxt.busy = 1'b1;
          cur_nxt.probe = sar_adc_pkg::TOP_BIT;
          cur_nxt.sar = sar_adc_pkg::TOP_BIT;
          cur_nxt.step_cnt = 8'h00;
        end
      end
      sar_adc_pkg::ST_DECIDE: begin
        if (cur_r.step_cnt == STEP_LAST) begin
          cur_nxt.step_cnt = 8'h00;
          cur_nxt.serial = cur_r.cmp_sync[1];
          cur_nxt.probe = cur_r.probe >> 1;
          cur_nxt.sar = decided | (cur_r.probe >> 1);
          if (cur_r.probe[0]) begin
            cur_nxt.state = sar_adc_pkg::ST_IDLE;
            cur_nxt.result = decided;
            cur_nxt.sar = decided;
            cur_nxt.busy = 1'b0;
          end
        end else begin
          cur_nxt.step_cnt = cur_r.step_cnt + 8'h01;
        end
      end
      default: begin
        cur_nxt.state = sar_adc_pkg::ST_IDLE;
        cur_nxt.busy = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cur_r <= '{trig_sync: sar_adc_pkg::SYNC_RST, inh_sync: 2'h0, cmp_sync: 2'h0, trig_prev: 1'b1,
                 state: sar_adc_pkg::ST_IDLE, step_cnt: 8'h00, probe: 12'h000, sar: 12'h000,
                 result: sar_adc_pkg::RESULT_RST, busy: 1'b0, serial: 1'b0};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign dac_code_out = cur_r.sar;
  assign busy_out = cur_r.busy;
  assign serial_data_out = cur_r.serial;
  assign result_out = cur_r.result;
  assign msb_n_out = ~cur_r.result[11];
  assign result_tc_out = twos_comp_in ? {~cur_r.result[11], cur_r.result[10:0]} : cur_r.result;

endmodule : sar_adc_control

// *** sar_adc_pkg.sv ***
// constants for the 12-bit successive-approximation converter sequencer
// assumes a single 40 MHz clock domain
package sar_adc_pkg;

  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned RES_BITS = 12;
  // conversion time limits in nanoseconds
  localparam int unsigned CONV_MIN_NS = 12000;
  localparam int unsigned CONV_MAX_NS = 48000;
  // conversion steps, one bit decision each
  localparam int unsigned CONV_STEPS = RES_BITS;
  // clock cycles per step: least rounds up, longest rounds down
  localparam int unsigned STEP_MIN_CYC = (CONV_MIN_NS * 1000 + CONV_STEPS * CLK_PERIOD_PS - 1)
                                         / (CONV_STEPS * CLK_PERIOD_PS);
  localparam int unsigned STEP_MAX_CYC = (CONV_MAX_NS * 1000) / (CONV_STEPS * CLK_PERIOD_PS);
  localparam int unsigned STEP_CNT_W = 8;
  // reset values and the first trial bit loaded at conversion start
  localparam logic [11:0] RESULT_RST = 12'h000;
  localparam logic [11:0] TOP_BIT = 12'h800;
  localparam logic [1:0] SYNC_RST = 2'h3;

  typedef enum {ST_IDLE, ST_DECIDE} seq_state_t;

endpackage : sar_adc_pkg

// *** tb_top.sv ***
// bench for the sequencer with a comparator model
`timescale 1ns/1ps
module tb_top;
  logic clk_in, rst_in, trigger_in, inhibit_n_in, twos_comp_in, comp_high_in, busy_out, serial_data_out, msb_n_out;
  logic [11:0] dac_code_out, result_out, result_tc_out, level;
  logic [11:0] lv [5] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'ha5c};
  int miscompares, checks;
  sar_adc_control #(.STEP_CYCLES(40)) sar_adc_control_i (.*);
  cmp_model cmp_model_i (.level_in(level), .dac_in(dac_code_out), .comp_high_out(comp_high_in));
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic pulse;
    @(posedge clk_in) #2 trigger_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #2 trigger_in = 1'b1;
  endtask : pulse
  task automatic wait_busy(input logic v);
    for (int n = 0; n < 600 && busy_out !== v; n++) @(negedge clk_in);
    chk(busy_out === v, "busy wait");
  endtask : wait_busy
  task automatic convert(input logic [11:0] x, input logic tc);
    level = x;
    twos_comp_in = tc;
    pulse();
    wait_busy(1'b1);
    for (int n = 1; n <= 480; n++) begin
      @(posedge clk_in) #2;
      if (n == 4) trigger_in = 1'b0;
      if (n == 8) trigger_in = 1'b1;
      if (n % 40 == 0) chk(serial_data_out === x[12 - n / 40], "serial bit");
      if (n == 479) chk(busy_out === 1'b1, "busy early fall");
      if (n == 480) chk(busy_out === 1'b0, "busy late fall");
    end
    wait_busy(1'b0);
    chk(result_out === x && msb_n_out === ~x[11], "result");
    chk(result_tc_out === (tc ? x ^ 12'h800 : x), "coded");
    level = ~x;
    repeat (20) @(negedge clk_in);
    chk(result_out === x, "hold");
  endtask : convert
  task automatic inhibited;
    @(posedge clk_in) #2 inhibit_n_in = 1'b0;
    repeat (4) @(posedge clk_in);
    pulse();
    repeat (10) @(negedge clk_in);
    chk(busy_out === 1'b0, "inhibit");
    @(posedge clk_in) #2 inhibit_n_in = 1'b1;
  endtask : inhibited
  task automatic stop_test;
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    {rst_in, trigger_in, inhibit_n_in, twos_comp_in, level} = {3'h7, 13'h0};
    repeat (20) @(posedge clk_in);
    #2 rst_in = 1'b0;
    inhibited();
    for (int i = 0; i < 5; i++) convert(lv[i], 1'(i % 2));
    stop_test();
  end
  initial begin
    #150us;
    miscompares++;
    stop_test();
  end
endmodule : tb_top
